// ### lfh_pkg.sv
package lfh_pkg;

   // ***************************************************************
   // Lane states handled here; ST_OUT means another state owns lane
   // ***************************************************************
   typedef enum logic [1:0] {
      ST_OUT = 2'b00,
      ST_FES = 2'b01,
      ST_HC  = 2'b10,
      ST_SR  = 2'b11
   } lfh_state_t;

   // ***************************************************************
   // Exit destinations
   // ***************************************************************
   typedef enum logic [2:0] {
      DST_NONE   = 3'b000,
      DST_COLD   = 3'b001,
      DST_CLEAR  = 3'b010,
      DST_BOTH   = 3'b011,
      DST_ACTIVE = 3'b100,
      DST_NEAR   = 3'b101,
      DST_FAR    = 3'b110
   } lfh_dest_t;

   // ***************************************************************
   // Received lane layer control words
   // ***************************************************************
   typedef enum logic [2:0] {
      RX_OTHER = 3'b000,
      RX_IDLE  = 3'b001,
      RX_INIT  = 3'b010,
      RX_IACK  = 3'b011,
      RX_RCLR  = 3'b100,
      RX_RXERR = 3'b101
   } lfh_rxw_t;

   typedef enum logic [1:0] {
      TX_NONE = 2'b00,
      TX_IDLE = 2'b01,
      TX_IACK = 2'b10
   } lfh_txw_t;

   typedef enum logic [1:0] {
      CS_NONE  = 2'b00,
      CS_RXERR = 2'b01,
      CS_RCLR  = 2'b10,
      CS_UPPER = 2'b11
   } lfh_cause_t;

   // ***************************************************************
   // Counts and timing
   // ***************************************************************
   localparam int CLK_PERIOD_PS    = 5000;
   localparam int INIT_TIMEOUT_US  = 20;
   localparam int REC_TIMEOUT_US   = 2;
   localparam int INIT_TIMEOUT_CYC =
      (INIT_TIMEOUT_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int REC_TIMEOUT_CYC  =
      (REC_TIMEOUT_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int TMR_W            = 12;
   localparam logic [TMR_W-1:0] TMR_RST = 12'h000;
   localparam logic [3:0] RXERR_LIMIT   = 4'h8;
   localparam logic [1:0] RUN_PAIR      = 2'h1;
   localparam logic [4:0] IACK_LAST     = 5'h0F;

endpackage : lfh_pkg

// ### lfh_lane_init.sv
`timescale 1ns/1ps
// Behaviour
// - Enter far-end-started from auto start after two IDLE words received.
// - Far-end-started entry starts a 20 us initialisation timeout.
// - Far-end-started sends IDLE words continuously and keeps receiving words.
// - Exits in priority: cold reset first, then warm reset or no signal.
// - More than eight consecutive RXERR in far-end or half connected: clear line.
// - Two INIT words in far-end-started lead to both-ends-started.
// - Initialisation timeout in far-end or half connected: clear line, lowest priority.
// - Half connected entered only from near-end-started after two IACK words.
// - Half connected sends sixteen IACK words, counting each one sent.
// - After the sixteenth IACK is sent, move to active.
// - Active enters start-recovery on RXERR run, RCLR, or upper error.
// - Start-recovery starts a 2 us recovery timeout, keeps receiving words.
// - RXERR run or upper error cause: exit to near-end-recovering.
// - RCLR cause: exit to far-end-recovering.
module lfh_lane_init
   import lfh_pkg::*;
(
   input  wire logic       clk_i,             // 200 MHz lane clock
   input  wire logic       rst_i,             // Sync reset, high
   input  wire logic       cold_reset_i,      // Cold reset request
   input  wire logic       warm_reset_i,      // Warm reset request
   input  wire logic       no_signal_i,       // Receiver sees no signal
   input  wire logic       auto_start_i,      // Lane in auto start (or polarity)
   input  wire logic       near_started_i,    // Lane in near-end-started
   input  wire logic       active_i,          // Lane in active
   input  wire logic       upper_err_i,       // Upper layer error pulse
   input  wire logic       rx_valid_i,        // Received word strobe
   input  wire lfh_rxw_t   rx_word_i,         // Received word kind
   input  wire logic       tx_taken_i,        // Offered word sent this cycle
   output logic            tx_send_o,         // Offer a word to send
   output lfh_txw_t        tx_word_o,         // Word kind offered
   output lfh_state_t      state_o,           // Current local state
   output logic            exit_valid_o,      // Exit pulse
   output lfh_dest_t       exit_dest_o,       // Exit destination
   output lfh_cause_t      cause_o,           // Latched recovery cause
   output logic            rec_timeout_o      // Recovery timeout pulse
);

   // ***************************************************************
   // Helpers
   // ***************************************************************
   function automatic logic [1:0] sat2(input logic [1:0] v);
      sat2 = (v == 2'h3) ? v : v + 2'h1;
   endfunction : sat2

   function automatic logic [3:0] sat4(input logic [3:0] v);
      sat4 = (v == 4'hF) ? v : v + 4'h1;
   endfunction : sat4

   lfh_state_t       state_q, state_d;
   lfh_dest_t        dest_q, dest_d;
   lfh_cause_t       cause_q, cause_d;
   lfh_rxw_t         run_word_q, run_word_d;
   logic [1:0]       run_cnt_q, run_cnt_d;
   logic [3:0]       err_cnt_q, err_cnt_d;
   logic [4:0]       iack_cnt_q, iack_cnt_d;
   logic [TMR_W-1:0] tmr_q, tmr_d;
   logic [TMR_W-1:0] rec_q, rec_d;
   logic             rec_run_q, rec_run_d;
   logic             rec_to_q, rec_to_d;
   logic             exit_q, exit_d;
   logic             send_q, send_d;
   lfh_txw_t         txw_q, txw_d;
   logic             two_idle, two_init, two_iack, err_run, hi_clear, init_exp;

   // ***************************************************************
   // Received word runs
   // ***************************************************************
   function automatic logic got_two(input lfh_rxw_t w, input lfh_rxw_t rw,
                                    input logic [1:0] rc, input logic v,
                                    input lfh_rxw_t nw);
      got_two = v && (nw == w) && (rw == w) && (rc >= RUN_PAIR);
   endfunction : got_two

   always_comb
   begin
      two_idle = got_two(RX_IDLE, run_word_q, run_cnt_q, rx_valid_i, rx_word_i);
      two_init = got_two(RX_INIT, run_word_q, run_cnt_q, rx_valid_i, rx_word_i);
      two_iack = got_two(RX_IACK, run_word_q, run_cnt_q, rx_valid_i, rx_word_i);
      err_run  = rx_valid_i && (rx_word_i == RX_RXERR) && (err_cnt_q >= RXERR_LIMIT);
      hi_clear = warm_reset_i || no_signal_i;
      init_exp = (tmr_q == TMR_W'(INIT_TIMEOUT_CYC - 1));
   end

   // ***************************************************************
   // Next state
   // ***************************************************************
   always_comb
   begin
      state_d    = state_q;
      dest_d     = DST_NONE;
      exit_d     = 1'b0;
      cause_d    = cause_q;
      iack_cnt_d = iack_cnt_q;
      tmr_d      = tmr_q + TMR_W'(1);
      run_word_d = run_word_q;
      run_cnt_d  = run_cnt_q;
      err_cnt_d  = err_cnt_q;
      if (rx_valid_i)
      begin
         run_word_d = rx_word_i;
         run_cnt_d  = (rx_word_i == run_word_q) ? sat2(run_cnt_q) : 2'h1;
         err_cnt_d  = (rx_word_i == RX_RXERR) ? sat4(err_cnt_q) : 4'h0;
      end
      case (state_q)
         ST_OUT:
         begin
            if (auto_start_i && two_idle)
            begin
               state_d = ST_FES;
               tmr_d   = TMR_RST;
            end
            else if (near_started_i && two_iack)
            begin
               state_d    = ST_HC;
               tmr_d      = TMR_RST;
               iack_cnt_d = 5'h00;
            end
            else if (active_i && (err_run || rx_valid_i && rx_word_i == RX_RCLR
                                  || upper_err_i))
            begin
               state_d = ST_SR;
               if (err_run)
                  cause_d = CS_RXERR;
               else if (rx_valid_i && rx_word_i == RX_RCLR)
                  cause_d = CS_RCLR;
               else
                  cause_d = CS_UPPER;
            end
         end
         ST_FES, ST_HC:
         begin
            if (state_q == ST_HC && send_q && tx_taken_i)
               iack_cnt_d = iack_cnt_q + 5'h01;
            if (cold_reset_i)
               dest_d = DST_COLD;
            else if (hi_clear)
               dest_d = DST_CLEAR;
            else if (err_run)
               dest_d = DST_CLEAR;
            else if (state_q == ST_FES && two_init)
               dest_d = DST_BOTH;
            else if (state_q == ST_HC && send_q && tx_taken_i
                     && iack_cnt_q == IACK_LAST)
               dest_d = DST_ACTIVE;
            else if (init_exp)
               dest_d = DST_CLEAR;
         end
         ST_SR:
         begin
            if (cold_reset_i)
               dest_d = DST_COLD;
            else if (hi_clear)
               dest_d = DST_CLEAR;
            else if (cause_q == CS_RCLR)
               dest_d = DST_FAR;
            else
               dest_d = DST_NEAR;
         end
         default:
            state_d = ST_OUT;
      endcase
      if (dest_d != DST_NONE)
      begin
         exit_d  = 1'b1;
         state_d = ST_OUT;
      end
      if (state_d != state_q)
         run_cnt_d = 2'h0;
   end

   // ***************************************************************
   // Transmit word selection
   // ***************************************************************
   always_comb
   begin
      send_d = (state_d == ST_FES) || (state_d == ST_HC && iack_cnt_d <= IACK_LAST);
      txw_d  = TX_NONE;
      if (state_d == ST_FES)
         txw_d = TX_IDLE;
      else if (state_d == ST_HC)
         txw_d = TX_IACK;
   end

   // ***************************************************************
   // Recovery timer, runs on past the exit for the recovering states
   // ***************************************************************
   always_comb
   begin
      rec_d     = rec_q;
      rec_run_d = rec_run_q;
      rec_to_d  = 1'b0;
      if (state_q == ST_SR)
      begin
         rec_d     = TMR_W'(1);
         rec_run_d = 1'b1;
      end
      else if (rec_run_q && cold_reset_i)
         rec_run_d = 1'b0;
      else if (rec_run_q)
      begin
         if (rec_q == TMR_W'(REC_TIMEOUT_CYC - 1))
         begin
            rec_run_d = 1'b0;
            rec_to_d  = 1'b1;
         end
         rec_d = rec_q + TMR_W'(1);
      end
   end

   // ***************************************************************
   // Registers
   // ***************************************************************
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_q    <= ST_OUT;
         dest_q     <= DST_NONE;
         exit_q     <= 1'b0;
         cause_q    <= CS_NONE;
         run_word_q <= RX_OTHER;
         run_cnt_q  <= 2'h0;
         err_cnt_q  <= 4'h0;
         iack_cnt_q <= 5'h00;
         tmr_q      <= TMR_RST;
         rec_q      <= TMR_RST;
         rec_run_q  <= 1'b0;
         rec_to_q   <= 1'b0;
         send_q     <= 1'b0;
         txw_q      <= TX_NONE;
      end
      else
      begin
         state_q    <= state_d;
         dest_q     <= dest_d;
         exit_q     <= exit_d;
         cause_q    <= cause_d;
         run_word_q <= run_word_d;
         run_cnt_q  <= run_cnt_d;
         err_cnt_q  <= err_cnt_d;
         iack_cnt_q <= iack_cnt_d;
         tmr_q      <= tmr_d;
         rec_q      <= rec_d;
         rec_run_q  <= rec_run_d;
         rec_to_q   <= rec_to_d;
         send_q     <= send_d;
         txw_q      <= txw_d;
      end
   end

   assign tx_send_o     = send_q;
   assign tx_word_o     = txw_q;
   assign state_o       = state_q;
   assign exit_valid_o  = exit_q;
   assign exit_dest_o   = dest_q;
   assign cause_o       = cause_q;
   assign rec_timeout_o = rec_to_q;

   // ***************************************************************
   // Checks
   // ***************************************************************
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   chk_fes_entry: assert property (
      state_q == ST_OUT && auto_start_i && two_idle |=> state_q == ST_FES)
      else $error("far end started not entered");
   chk_init_timer: assert property (
      $rose(state_q == ST_FES) |-> tmr_q == TMR_RST)
      else $error("init timer not restarted");
   chk_tx_idle: assert property (
      state_q == ST_FES |-> send_q && txw_q == TX_IDLE)
      else $error("idle not sent");
   chk_cold_exit: assert property (
      state_q != ST_OUT && cold_reset_i |=> exit_q && dest_q == DST_COLD)
      else $error("cold reset exit wrong");
   chk_rxerr_exit: assert property (
      (state_q == ST_FES || state_q == ST_HC) && !cold_reset_i && !hi_clear
      && err_run |=> exit_q && dest_q == DST_CLEAR)
      else $error("rxerr run exit wrong");
   chk_init_exit: assert property (
      state_q == ST_FES && !cold_reset_i && !hi_clear && !err_run && two_init
      |=> dest_q == DST_BOTH ##1 state_q == ST_OUT)
      else $error("init pair exit wrong");
   chk_timeout_exit: assert property (
      state_q == ST_FES && init_exp && !cold_reset_i && !hi_clear && !err_run
      && !two_init |=> dest_q == DST_CLEAR)
      else $error("init timeout exit wrong");
   chk_hc_entry: assert property (
      $rose(state_q == ST_HC) |-> $past(near_started_i) && $past(two_iack))
      else $error("half connected entry wrong");
   chk_iack_count: assert property (
      state_q == ST_HC && send_q && tx_taken_i && iack_cnt_q == IACK_LAST
      && !cold_reset_i && !hi_clear && !err_run |=> dest_q == DST_ACTIVE)
      else $error("sixteenth iack exit wrong");
   chk_sr_exit: assert property (
      state_q == ST_SR && !cold_reset_i && !hi_clear
      |=> dest_q == ($past(cause_q) == CS_RCLR ? DST_FAR : DST_NEAR))
      else $error("recovery exit wrong");
   chk_rec_timer: assert property (
      state_q == ST_SR && !cold_reset_i |=> rec_run_q && rec_q == TMR_W'(1))
      else $error("recovery timer not started");

endmodule : lfh_lane_init

// ### lfh_peer.sv
`timescale 1ns/1ps
module lfh_peer
   import lfh_pkg::*;
(
   input  wire logic clk_i,      // Lane clock
   input  wire logic tx_send_i,  // Word offered
   input  wire logic fast_i,     // Take every cycle
   output logic      rx_valid_o, // Word strobe
   output lfh_rxw_t  rx_word_o,  // Word kind
   output logic      tx_taken_o, // Word taken
   output int        taken_o     // Words taken
);
   initial
   begin
      rx_valid_o = 1'b0;
      rx_word_o  = RX_OTHER;
      tx_taken_o = 1'b0;
      taken_o    = 0;
   end

   // Slow mode takes every other cycle
   always @(posedge clk_i)
   begin
      if (tx_send_i && tx_taken_o)
         taken_o <= taken_o + 1;
      tx_taken_o <= tx_send_i && (fast_i || !tx_taken_o);
   end

   // Back-to-back words, then a changed kind while idle
   task automatic send_words(input lfh_rxw_t kind, input int n);
      for (int i = 0; i < n; i++)
      begin
         @(posedge clk_i);
         rx_valid_o <= 1'b1;
         rx_word_o  <= kind;
      end
      @(posedge clk_i);
      rx_valid_o <= 1'b0;
      rx_word_o  <= lfh_rxw_t'(3'(kind) ^ 3'h1);
   endtask : send_words
endmodule : lfh_peer

// ### lane_init_farend_halfconn_recovery_tb_top.sv
`timescale 1ns/1ps
module lane_init_farend_halfconn_recovery_tb_top
   import lfh_pkg::*;
;
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic       cold = 1'b0;
   logic       warm = 1'b0;
   logic       nosig = 1'b0;
   logic       auto_st = 1'b0;
   logic       near = 1'b0;
   logic       act = 1'b0;
   logic       uerr = 1'b0;
   logic       fast = 1'b1;
   logic       rx_valid, tx_taken, tx_send_o, exit_valid_o, rec_timeout_o;
   lfh_rxw_t   rx_word;
   lfh_txw_t   tx_word_o;
   lfh_state_t state_o;
   lfh_dest_t  exit_dest_o;
   lfh_cause_t cause_o;
   int         taken;
   int         fails = 0;
   int         total_checks = 0;
   int         cycles = 0;

   always #2.5 clk = ~clk;

   lfh_lane_init lfh_lane_init_inst (
      .clk_i(clk), .rst_i(rst), .cold_reset_i(cold), .warm_reset_i(warm),
      .no_signal_i(nosig), .auto_start_i(auto_st), .near_started_i(near),
      .active_i(act), .upper_err_i(uerr), .rx_valid_i(rx_valid),
      .rx_word_i(rx_word), .tx_taken_i(tx_taken), .tx_send_o(tx_send_o),
      .tx_word_o(tx_word_o), .state_o(state_o), .exit_valid_o(exit_valid_o),
      .exit_dest_o(exit_dest_o), .cause_o(cause_o), .rec_timeout_o(rec_timeout_o));

   lfh_peer lfh_peer_inst (
      .clk_i(clk), .tx_send_i(tx_send_o), .fast_i(fast), .rx_valid_o(rx_valid),
      .rx_word_o(rx_word), .tx_taken_o(tx_taken), .taken_o(taken));

   // ***************************************************************
   // Helpers
   // ***************************************************************
   task automatic give_verdict;
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : give_verdict

   always @(posedge clk)
   begin
      cycles++;
      if (cycles > 30000)
      begin
         fails++;
         give_verdict();
      end
   end

   task automatic chk(input bit ok, input string msg);
      total_checks++;
      if (!ok)
      begin
         fails++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc

   task automatic wait_exit(input lfh_dest_t d, input int n);
      // Step off the edge so a pulse launched on it is seen
      #1;
      for (int i = 0; i < n && exit_valid_o !== 1'b1; i++)
         @(posedge clk) #1;
      chk(exit_valid_o === 1'b1 && exit_dest_o === d && state_o === ST_OUT, "bad exit");
   endtask : wait_exit

   task automatic enter_fes;
      @(posedge clk);
      auto_st <= 1'b1;
      lfh_peer_inst.send_words(RX_IDLE, 2);
      #1;
      chk(state_o === ST_FES && tx_send_o && tx_word_o === TX_IDLE, "fes entry");
      @(posedge clk);
      auto_st <= 1'b0;
   endtask : enter_fes

   // ***************************************************************
   // Scenarios
   // ***************************************************************
   task automatic t_fes_both;
      @(posedge clk);
      auto_st <= 1'b1;
      lfh_peer_inst.send_words(RX_IDLE, 1);
      lfh_peer_inst.send_words(RX_OTHER, 1);
      #1;
      chk(state_o === ST_OUT, "entry on one idle");
      @(posedge clk);
      auto_st <= 1'b0;
      enter_fes();
      lfh_peer_inst.send_words(RX_INIT, 1);
      lfh_peer_inst.send_words(RX_IDLE, 1);
      #1;
      chk(state_o === ST_FES, "exit on one init");
      lfh_peer_inst.send_words(RX_INIT, 2);
      wait_exit(DST_BOTH, 2);
   endtask : t_fes_both

   task automatic t_fes_rxerr;
      enter_fes();
      lfh_peer_inst.send_words(RX_RXERR, 8);
      #1;
      chk(state_o === ST_FES, "exit on eight errors");
      lfh_peer_inst.send_words(RX_OTHER, 1);
      lfh_peer_inst.send_words(RX_RXERR, 9);
      wait_exit(DST_CLEAR, 2);
   endtask : t_fes_rxerr

   task automatic t_prio;
      lfh_dest_t d [3] = '{DST_COLD, DST_CLEAR, DST_CLEAR};
      for (int k = 0; k < 3; k++)
      begin
         enter_fes();
         @(posedge clk);
         cold  <= (k == 0);
         warm  <= (k < 2);
         nosig <= (k == 2);
         wait_exit(d[k], 3);
         cyc(3);
         chk(exit_valid_o === 1'b0 && state_o === ST_OUT, "exit outside");
         @(posedge clk);
         cold  <= 1'b0;
         warm  <= 1'b0;
         nosig <= 1'b0;
      end
   endtask : t_prio

   task automatic t_fes_timeout;
      enter_fes();
      cyc(INIT_TIMEOUT_CYC - 2);
      chk(state_o === ST_FES, "early timeout");
      wait_exit(DST_CLEAR, 1);
   endtask : t_fes_timeout

   task automatic t_hc;
      int t0;
      lfh_peer_inst.send_words(RX_IACK, 2);
      #1;
      chk(state_o === ST_OUT, "entry without near start");
      @(posedge clk);
      near <= 1'b1;
      fast <= 1'b0;
      t0 = taken;
      lfh_peer_inst.send_words(RX_OTHER, 1);
      lfh_peer_inst.send_words(RX_IACK, 1);
      #1;
      chk(state_o === ST_OUT, "entry on one iack");
      lfh_peer_inst.send_words(RX_IACK, 1);
      #1;
      chk(state_o === ST_HC && tx_send_o && tx_word_o === TX_IACK, "hc entry");
      @(posedge clk);
      near <= 1'b0;
      wait_exit(DST_ACTIVE, 60);
      chk(taken - t0 === 16 && tx_send_o === 1'b0, "iack count");
   endtask : t_hc

   task automatic t_sr;
      lfh_cause_t c [3] = '{CS_RCLR, CS_UPPER, CS_RXERR};
      lfh_dest_t  d [3] = '{DST_FAR, DST_NEAR, DST_NEAR};
      int         n;
      for (int k = 0; k < 3; k++)
      begin
         @(posedge clk);
         act <= 1'b1;
         if (k == 0)
            lfh_peer_inst.send_words(RX_RCLR, 1);
         if (k == 1)
         begin
            @(posedge clk);
            uerr <= 1'b1;
            @(posedge clk);
            uerr <= 1'b0;
         end
         if (k == 2)
            lfh_peer_inst.send_words(RX_RXERR, 9);
         #1;
         chk(state_o === ST_SR && cause_o === c[k], "recovery cause");
         wait_exit(d[k], 2);
         @(posedge clk);
         act <= 1'b0;
         n = 0;
         while (rec_timeout_o !== 1'b1 && n < 500)
         begin
            @(posedge clk) #1;
            n++;
         end
         chk(n == REC_TIMEOUT_CYC - 2, "recovery timeout");
      end
   endtask : t_sr

   initial
   begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      cyc(1);
      chk(state_o === ST_OUT && !exit_valid_o && !tx_send_o && cause_o === CS_NONE, "reset");
      t_fes_both();
      t_fes_rxerr();
      t_prio();
      t_fes_timeout();
      t_hc();
      t_sr();
      give_verdict();
   end
endmodule : lane_init_farend_halfconn_recovery_tb_top
